// File: dv/remote_station.sv
`timescale 1ns/1ps
module remote_station (
  input  wire logic sys_clk,
  input  wire logic serial_tx_line,
  input  int        bit_cyc,
  output logic      serial_rx_line
);
  logic [9:0] got_q[$];
  logic [9:0] sh;
  initial serial_rx_line = 1'b1;
  // sends one frame, then idles high for a bit time
  task automatic send(input logic [7:0] d, input logic nine, b8, stop);
    logic [10:0] f;
    f = nine ? {stop, b8, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      serial_rx_line <= f[i];
      repeat (bit_cyc) @(posedge sys_clk);
    end
    serial_rx_line <= 1'b1;
    repeat (bit_cyc) @(posedge sys_clk);
  endtask
  // captures the ten bits after each start bit, sampled mid bit
  always begin
    @(negedge serial_tx_line);
    repeat (bit_cyc / 2) @(negedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_cyc) @(negedge sys_clk);
      sh[i] = serial_tx_line;
    end
    got_q.push_back(sh);
  end
endmodule

// File: dv/tb_uart_with_reload_baud_generator.sv
`timescale 1ns/1ps
module tb_uart_with_reload_baud_generator;
  import uart1_pkg::*;
  logic       sys_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic       clk_en = 1'b1;
  logic [9:0] got, fexp;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, v, d, ctl, hold;
  logic       serial_rx_line, serial_tx_line, irq;
  logic [7:0] regs[6] = '{CONTROL_ADDR, BUFFER_ADDR, RELOAD_ADDR,
                          STATUS_ADDR, MASK_ADDR, 8'h50};
  logic [11:0] rxc[7] = '{12'h10d, 12'h300, 12'h303, 12'hb0f, 12'hb0a,
                          12'h00a, 12'h909};
  int bit_cyc = 32, miscompares = 0, cmp_count = 0, seed = 32'hedd5;
  always #4 sys_clk = ~sys_clk;
  uart1_core i_dut (.sys_clk, .rst, .clk_en, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data, .serial_rx_line, .serial_tx_line, .irq);
  remote_station i_far (.sys_clk, .serial_tx_line, .bit_cyc,
    .serial_rx_line);
  task automatic chk(input logic [9:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_frame(input logic [9:0] got, exp);
    chk(got, exp);
  endtask
  task automatic chk_irq(input logic got, exp);
    chk({9'h000, got}, {9'h000, exp});
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, dd);
    @(posedge sys_clk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wr_data <= dd;
  endtask
  task automatic idle();
    @(posedge sys_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, dd);
    bus(1'b1, a, dd);
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dd);
    bus(1'b0, a, 8'h00);
    idle();
    @(negedge sys_clk) dd = rd_data;
  endtask
  task automatic irq_status(input logic [1:0] ev);
    chk_irq(irq, ev != 2'h0);
    rd(STATUS_ADDR, v);
    chk(v, {6'h00, ev});
    @(posedge sys_clk);
    @(negedge sys_clk) chk_irq(irq, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (regs[i]) begin
      rd(regs[i], v);
      chk(v, 8'h00);
    end
    bus(1'b1, RELOAD_ADDR, 8'hff);
    rd(RELOAD_ADDR, v);
    chk(v, 8'hff);
    wr(MASK_ADDR, 8'h03);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(MASK_ADDR, 8'h00);
    clk_en <= 1'b1;
    rd(MASK_ADDR, v);
    chk(v, 8'h03);
    // let the baud timer reach its first overflow and start reloading
    repeat (520) @(posedge sys_clk);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      if (k == 4) begin
        wr(RELOAD_ADDR, 8'hfe);
        bit_cyc = 64;
      end
      d = 8'($random(seed));
      ctl = {k > 1, 3'h0, k[0], 3'h0};
      wr(CONTROL_ADDR, ctl);
      wr(BUFFER_ADDR, d);
      for (int n = 0; n < 2000 && i_far.got_q.size() == 0; n++)
        @(posedge sys_clk);
      if (i_far.got_q.size() == 0) begin
        miscompares++;
        complete_run();
      end
      got = i_far.got_q.pop_front();
      fexp = {1'b1, k > 1 ? k[0] : 1'b1, d};
      chk_frame(got, fexp);
      rd(CONTROL_ADDR, v);
      chk(v, ctl | 8'h02);
      irq_status(2'h2);
    end
    $display("test transmit done");
    hold = 8'h00;
    foreach (rxc[j]) begin
      d = 8'($random(seed));
      wr(CONTROL_ADDR, rxc[j][11:4]);
      i_far.send(d, rxc[j][11], rxc[j][2], rxc[j][1]);
      rd(CONTROL_ADDR, v);
      if (rxc[j][0]) begin
        hold = d;
        chk(v, rxc[j][11:4] | {5'h00, rxc[j][11] ? rxc[j][2] : rxc[j][1],
            2'h1});
      end else begin
        chk(v & 8'hfb, rxc[j][11:4]);
      end
      rd(BUFFER_ADDR, v);
      chk(v, hold);
      irq_status({1'b0, rxc[j][0]});
    end
    $display("test receive done");
    complete_run();
  end
endmodule

// File: dv/uart1_props.sv
`timescale 1ns/1ps
module uart1_props
  import uart1_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       serial_rx_line,
  input wire logic       serial_tx_line,
  input wire logic       irq
);
  logic [1:0] msk_reg;
  logic [7:0] ctl_reg;
  // shadow copies of software-owned fields
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      msk_reg <= 2'h0;
      ctl_reg <= 8'h00;
    end else if (clk_en && wr_en && addr == MASK_ADDR) begin
      msk_reg <= wr_data[1:0];
    end else if (clk_en && wr_en && addr == CONTROL_ADDR) begin
      ctl_reg <= wr_data;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE_ZERO: assert property (
    !$past(rd_en) |-> rd_data == 8'h00) else $error("read data not idle");
  AST_UNMAPPED_ZERO: assert property (
    rd_en && (addr < CONTROL_ADDR || addr > MASK_ADDR) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  AST_CTL_RSVD_ZERO: assert property (
    rd_en && addr == CONTROL_ADDR |=> !rd_data[6])
    else $error("reserved control bit set");
  AST_RELOAD_READBACK: assert property (
    wr_en && addr == RELOAD_ADDR ##1 rd_en && addr == RELOAD_ADDR
    |=> rd_data == $past(wr_data, 2)) else $error("reload readback wrong");
  AST_TX_START_LOW: assert property (
    wr_en && addr == BUFFER_ADDR |=> !serial_tx_line [*8])
    else $error("start bit missing");
  AST_IRQ_MASKED_OFF: assert property (
    $past(msk_reg) == 2'h0 && msk_reg == 2'h0 |-> !irq)
    else $error("irq with mask clear");
  AST_MASK_READBACK: assert property (
    rd_en && addr == MASK_ADDR |=> rd_data == {6'h00, msk_reg})
    else $error("mask readback wrong");
  AST_CTL_SW_BITS: assert property (
    rd_en && addr == CONTROL_ADDR |=> (rd_data & 8'hb8) == (ctl_reg & 8'hb8))
    else $error("software control bits changed");
endmodule

bind uart1_core uart1_props i_props (.sys_clk, .rst, .clk_en, .addr,
  .wr_data, .wr_en, .rd_en, .rd_data, .serial_rx_line, .serial_tx_line, .irq);

// File: rtl/uart1_core.sv
`timescale 1ns/1ps
module uart1_core (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  input  wire logic [uart1_pkg::ADDR_W-1:0] addr,
  input  wire logic [uart1_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [uart1_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       serial_rx_line,
  output logic                            serial_tx_line,
  output logic                            irq
);
  import uart1_pkg::*;

  // register file state
  logic [7:0]     control_reg, control_next;
  logic [7:0]     reload_reg, reload_next;
  logic [7:0]     rx_hold_reg, rx_hold_next;
  logic [1:0]     status_reg, status_next;
  logic [1:0]     mask_reg, mask_next;
  logic [7:0]     rd_data_reg, rd_data_next;
  logic           irq_reg, irq_next;

  // baud generator state
  logic           half_reg, half_next;
  logic [7:0]     timer_reg, timer_next;
  logic           tick_reg, tick_next;

  // transmitter state
  tx_state_e      tx_state_reg, tx_state_next;
  logic [3:0]     tx_cnt_reg, tx_cnt_next;
  logic [2:0]     tx_bit_reg, tx_bit_next;
  logic [7:0]     tx_shift_reg, tx_shift_next;
  logic           tx_line_reg, tx_line_next;
  logic           tx_event;

  // receiver state
  logic           rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic           rx_meta_next, rx_sync_next, rx_prev_next;
  rx_state_e      rx_state_reg, rx_state_next;
  logic [3:0]     rx_cnt_reg, rx_cnt_next;
  logic [2:0]     rx_bit_reg, rx_bit_next;
  logic [7:0]     rx_shift_reg, rx_shift_next;
  logic           rx_ninth_reg, rx_ninth_next;
  logic           rx_event;
  logic           rx_ninth_value;

  logic           wr_buffer;
  logic           nine_mode;

  assign wr_buffer = wr_en && (addr == BUFFER_ADDR);
  assign nine_mode = control_reg[CTL_NINE];

  // baud generator: divide by two, then 8-bit timer reloading on overflow
  // the timer climbs from zero to its first overflow before any reload
  always_comb begin
    half_next  = ~half_reg;
    timer_next = timer_reg;
    tick_next  = 1'b0;
    if (half_reg) begin
      if (timer_reg == TIMER_TOP) begin
        timer_next = reload_reg;
        tick_next  = 1'b1;
      end else begin
        timer_next = timer_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      half_reg  <= 1'b0;
      timer_reg <= 8'h00;
      tick_reg  <= 1'b0;
    end else if (clk_en) begin
      half_reg  <= half_next;
      timer_reg <= timer_next;
      tick_reg  <= tick_next;
    end
  end

  // transmitter
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next   = tx_cnt_reg;
    tx_bit_next   = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    tx_event      = 1'b0;
    // a buffer write aborts any frame in flight and restarts
    if (wr_buffer) begin
      tx_shift_next = wr_data;
      tx_state_next = TX_START;
      tx_cnt_next   = 4'h0;
      tx_bit_next   = 3'h0;
    end else if (tick_reg) begin
      tx_cnt_next = tx_cnt_reg + 4'h1;
      if (tx_cnt_reg == LAST_TICK) begin
        case (tx_state_reg)
          TX_START: begin
            tx_state_next = TX_DATA;
          end
          TX_DATA: begin
            tx_shift_next = {1'b0, tx_shift_reg[7:1]};
            tx_bit_next   = tx_bit_reg + 3'h1;
            if (tx_bit_reg == LAST_DATA_BIT) begin
              if (nine_mode) begin
                tx_state_next = TX_NINTH;
              end else begin
                tx_state_next = TX_STOP;
                tx_event      = 1'b1;
              end
            end
          end
          TX_NINTH: begin
            tx_state_next = TX_STOP;
            tx_event      = 1'b1;
          end
          TX_STOP: begin
            tx_state_next = TX_IDLE;
          end
          default: begin
            tx_state_next = TX_IDLE;
          end
        endcase
      end
    end
    case (tx_state_next)
      TX_START: tx_line_next = 1'b0;
      TX_DATA:  tx_line_next = tx_shift_next[0];
      TX_NINTH: tx_line_next = control_reg[CTL_TX_NINTH];
      default:  tx_line_next = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_line_reg  <= 1'b1;
    end else if (clk_en) begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_bit_reg   <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      tx_line_reg  <= tx_line_next;
    end
  end

  // receive line synchroniser; idles high so reset gives no false start
  always_comb begin
    rx_meta_next = serial_rx_line;
    rx_sync_next = rx_meta_reg;
    rx_prev_next = rx_sync_reg;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else if (clk_en) begin
      rx_meta_reg <= rx_meta_next;
      rx_sync_reg <= rx_sync_next;
      rx_prev_reg <= rx_prev_next;
    end
  end

  // receiver
  always_comb begin
    rx_state_next  = rx_state_reg;
    rx_cnt_next    = rx_cnt_reg;
    rx_bit_next    = rx_bit_reg;
    rx_shift_next  = rx_shift_reg;
    rx_ninth_next  = rx_ninth_reg;
    rx_event       = 1'b0;
    rx_ninth_value = rx_ninth_reg;
    if (!control_reg[CTL_RX_EN]) begin
      rx_state_next = RX_IDLE;
    end else if (rx_state_reg == RX_IDLE) begin
      if (rx_prev_reg && !rx_sync_reg) begin
        rx_state_next = RX_START;
        rx_cnt_next   = 4'h0;
        rx_bit_next   = 3'h0;
      end
    end else if (tick_reg) begin
      rx_cnt_next = rx_cnt_reg + 4'h1;
      case (rx_state_reg)
        RX_START: begin
          // line back high mid start bit: noise, not a frame
          if (rx_cnt_reg == SAMPLE_TICK && rx_sync_reg) begin
            rx_state_next = RX_IDLE;
          end else if (rx_cnt_reg == LAST_TICK) begin
            rx_state_next = RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cnt_reg == SAMPLE_TICK) begin
            rx_shift_next = {rx_sync_reg, rx_shift_reg[7:1]};
          end
          if (rx_cnt_reg == LAST_TICK) begin
            rx_bit_next = rx_bit_reg + 3'h1;
            if (rx_bit_reg == LAST_DATA_BIT) begin
              rx_state_next = nine_mode ? RX_NINTH : RX_STOP;
            end
          end
        end
        RX_NINTH: begin
          if (rx_cnt_reg == SAMPLE_TICK) begin
            rx_ninth_next = rx_sync_reg;
          end
          if (rx_cnt_reg == LAST_TICK) begin
            rx_state_next = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_cnt_reg == SAMPLE_TICK) begin
            // a new start may be caught right after the stop midpoint
            rx_state_next = RX_IDLE;
            if (nine_mode) begin
              rx_ninth_value = rx_ninth_reg;
              rx_event = !(control_reg[CTL_FILTER] && !rx_ninth_reg);
            end else begin
              rx_ninth_value = rx_sync_reg;
              rx_event = !(control_reg[CTL_FILTER] && !rx_sync_reg);
            end
          end
        end
        default: begin
          rx_state_next = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_ninth_reg <= 1'b0;
    end else if (clk_en) begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg   <= rx_cnt_next;
      rx_bit_reg   <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_ninth_reg <= rx_ninth_next;
    end
  end

  // register file, flags and interrupt
  always_comb begin
    control_next = control_reg;
    reload_next  = reload_reg;
    rx_hold_next = rx_hold_reg;
    status_next  = status_reg;
    mask_next    = mask_reg;
    rd_data_next = 8'h00;
    if (wr_en) begin
      case (addr)
        CONTROL_ADDR: control_next = wr_data & CTL_WR_MASK;
        RELOAD_ADDR:  reload_next  = wr_data;
        MASK_ADDR:    mask_next    = wr_data[1:0];
        default:      control_next = control_reg;
      endcase
    end
    // read data stand one cycle; reading status clears it
    if (rd_en) begin
      case (addr)
        CONTROL_ADDR: rd_data_next = control_reg;
        BUFFER_ADDR:  rd_data_next = rx_hold_reg;
        RELOAD_ADDR:  rd_data_next = reload_reg;
        STATUS_ADDR: begin
          rd_data_next = {6'h00, status_reg};
          status_next  = EV_NONE;
        end
        MASK_ADDR:    rd_data_next = {6'h00, mask_reg};
        default:      rd_data_next = 8'h00;
      endcase
    end
    // hardware sets come last so they win over a same-cycle clear
    if (rx_event) begin
      rx_hold_next              = rx_shift_reg;
      control_next[CTL_RX_NINTH] = rx_ninth_value;
      control_next[CTL_RX_DONE]  = 1'b1;
      status_next[EV_RX]         = 1'b1;
    end else if (rx_state_reg == RX_STOP && rx_cnt_reg == SAMPLE_TICK
                 && tick_reg && !nine_mode && !control_reg[CTL_FILTER])
    begin
      control_next[CTL_RX_NINTH] = rx_ninth_value;
    end
    if (tx_event) begin
      control_next[CTL_TX_DONE] = 1'b1;
      status_next[EV_TX]        = 1'b1;
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_reg <= CONTROL_RST;
      reload_reg  <= RELOAD_RST;
      rx_hold_reg <= HOLD_RST;
      status_reg  <= STATUS_RST;
      mask_reg    <= MASK_RST;
      rd_data_reg <= 8'h00;
      irq_reg     <= 1'b0;
    end else if (clk_en) begin
      control_reg <= control_next;
      reload_reg  <= reload_next;
      rx_hold_reg <= rx_hold_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      rd_data_reg <= rd_data_next;
      irq_reg     <= irq_next;
    end
  end

  assign rd_data        = rd_data_reg;
  assign serial_tx_line = tx_line_reg;
  assign irq            = irq_reg;
endmodule

// File: rtl/uart1_pkg.sv
package uart1_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 8;
  localparam int          OVERSAMPLE    = 16;
  localparam int          CNT_W         = 4;
  localparam int          BIT_IDX_W     = 3;
  localparam logic [3:0]  SAMPLE_TICK   = 4'h7;
  localparam logic [3:0]  LAST_TICK     = 4'(OVERSAMPLE - 1);
  localparam logic [2:0]  LAST_DATA_BIT = 3'h7;
  localparam logic [7:0]  TIMER_TOP     = 8'hff;
  // register offsets
  localparam logic [7:0]  CONTROL_ADDR  = 8'h9b;
  localparam logic [7:0]  BUFFER_ADDR   = 8'h9c;
  localparam logic [7:0]  RELOAD_ADDR   = 8'h9d;
  localparam logic [7:0]  STATUS_ADDR   = 8'h9e;
  localparam logic [7:0]  MASK_ADDR     = 8'h9f;
  // control field positions
  localparam int          CTL_NINE      = 7;
  localparam int          CTL_FILTER    = 5;
  localparam int          CTL_RX_EN     = 4;
  localparam int          CTL_TX_NINTH  = 3;
  localparam int          CTL_RX_NINTH  = 2;
  localparam int          CTL_TX_DONE   = 1;
  localparam int          CTL_RX_DONE   = 0;
  localparam logic [7:0]  CTL_WR_MASK   = 8'hbf;
  // status and mask field positions
  localparam int          EV_RX         = 0;
  localparam int          EV_TX         = 1;
  localparam logic [1:0]  EV_NONE       = 2'h0;
  // reset values
  localparam logic [7:0]  CONTROL_RST   = 8'h00;
  localparam logic [7:0]  RELOAD_RST    = 8'h00;
  localparam logic [7:0]  HOLD_RST      = 8'h00;
  localparam logic [1:0]  STATUS_RST    = 2'h0;
  localparam logic [1:0]  MASK_RST      = 2'h0;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP
  } rx_state_e;
endpackage
